//--- rtl/epiu_map.svh
// epiu_map.svh: register offsets, field ranges and reset values
// assumes: included by bare name; definitions only
`ifndef EPIU_MAP_SVH
`define EPIU_MAP_SVH
// bus geometry
`define EPIU_ADDR_W     6
`define EPIU_DATA_W     32
`define EPIU_PC_W       24
// register byte offsets
`define EPIU_OFS_SENSE  6'h00
`define EPIU_OFS_EN     6'h04
`define EPIU_OFS_FLAG   6'h08
`define EPIU_OFS_PCEN   6'h0C
`define EPIU_OFS_PCFLAG 6'h10
`define EPIU_OFS_PIN_CHANGE_MASK_ZERO 6'h14
`define EPIU_OFS_PIN_CHANGE_MASK_ONE 6'h18
`define EPIU_OFS_PIN_CHANGE_MASK_TWO 6'h1C
`define EPIU_OFS_PINS   6'h20
// field ranges
`define EPIU_S0         1:0
`define EPIU_S1         3:2
`define EPIU_G0         7:0
`define EPIU_G1         15:8
`define EPIU_G2         23:16
`define EPIU_G1_LIVE    6:0
`define EPIU_GRP_W      8
// reset values
`define EPIU_RST_REGS   '0
`define EPIU_RST_PINS   '1
`endif

//--- rtl/epiu_pkg.sv
// epiu_pkg.sv: types of the external pin interrupt unit
// assumes: epiu_map.svh sits beside it
`include "epiu_map.svh"
package epiu_pkg;
    // trigger condition of a dedicated pin
    typedef enum logic [1:0] {
        EPIU_LOW  = 2'b00,
        EPIU_ANY  = 2'b01,
        EPIU_FALL = 2'b10,
        EPIU_RISE = 2'b11
    } epiu_sense_type;
    // bus slave states
    typedef enum logic {
        EPIU_IDLE = 1'b0,
        EPIU_ACK  = 1'b1
    } epiu_bus_st_type;
    typedef struct packed {
        epiu_bus_st_type st;
        logic [31:0]     rdata;
    } epiu_bus_type;
    typedef struct packed {
        logic [1:0]  ext_s1;
        logic [1:0]  ext_s2;
        logic [1:0]  ext_prev;
        logic [23:0] pc_s1;
        logic [23:0] pc_s2;
        logic [23:0] pc_prev;
    } epiu_det_type;
    typedef struct packed {
        logic [3:0]  sense;
        logic [1:0]  en;
        logic [1:0]  flag;
        logic [2:0]  pcen;
        logic [2:0]  pcflag;
        logic [23:0] pcmsk;
    } epiu_regs_type;
endpackage

//--- rtl/epiu_if.sv
// epiu_if.sv: bundle between the core, bus slave and detectors
// assumes: one instance inside epiu_top
`include "epiu_map.svh"
interface epiu_if;
    logic                    wr;
    logic [`EPIU_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic [7:0]              rdata;
    logic [3:0]              sense;
    logic [23:0]             pcmsk;
    logic [23:0]             pc_prev;
    logic [1:0]              ext_lvl;
    logic [1:0]              ext_evt;
    logic [2:0]              pc_evt;
    modport bus (output wr, addr, wdata, input rdata);
    modport det (input sense, pcmsk,
                 output ext_lvl, ext_evt, pc_evt, pc_prev);
endinterface

//--- rtl/epiu_sync_det.sv
// epiu_sync_det.sv: pin synchronisers and edge/change detectors
// assumes: pins asynchronous; i_io_en low while the io clock halts
`include "epiu_map.svh"
module epiu_sync_det
    import epiu_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    // pins and io clock gate
    input  wire logic [1:0]  i_ext_pins,
    input  wire logic [23:0] i_pc_pins,
    input  wire logic        i_io_en,
    // detector side of the bundle
    epiu_if.det              det
);
    epiu_det_type q;
    epiu_det_type d;
    logic [23:0]  pc_chg;

    // does the sample pair match the selected edge
    function automatic logic edge_hit(input logic [1:0] s,
                                      input logic now, input logic old);
        case (epiu_sense_type'(s))
            EPIU_ANY:  edge_hit = now ^ old;
            EPIU_FALL: edge_hit = old & ~now;
            EPIU_RISE: edge_hit = now & ~old;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

    // sample pins, compare against the previous sample
    always_comb begin
        d = q;
        det.ext_evt = 2'h0;
        det.pc_evt = 3'h0;
        if (i_io_en) begin // RL6 RL7
            d.ext_s1 = i_ext_pins; // RL1 RL10 RL22
            d.ext_s2 = q.ext_s1;
            d.ext_prev = q.ext_s2;
            d.pc_s1 = i_pc_pins;
            d.pc_s2 = q.pc_s1;
            d.pc_prev = q.pc_s2;
            det.ext_evt[0] = edge_hit(det.sense[`EPIU_S0],
                                      q.ext_s2[0], q.ext_prev[0]); // RL22
            det.ext_evt[1] = edge_hit(det.sense[`EPIU_S1],
                                      q.ext_s2[1], q.ext_prev[1]); // RL22
            for (int g = 0; g < 3; g++) begin
                det.pc_evt[g] =
                    |pc_chg[`EPIU_GRP_W*g +: `EPIU_GRP_W]; // RL2 RL3
            end
        end
    end

    assign det.ext_lvl = q.ext_s2;
    assign det.pc_prev = q.pc_prev;
    assign pc_chg = (q.pc_s2 ^ q.pc_prev) & det.pcmsk; // RL3

    // state register, pins assumed idle high at reset
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= `EPIU_RST_PINS;
        end else begin
            q <= d;
        end
    end
endmodule

//--- rtl/epiu_avmm.sv
// epiu_avmm.sv: avalon-mm slave with one wait state
// assumes: master holds its request until waitrequest is low
`include "epiu_map.svh"
module epiu_avmm
    import epiu_pkg::*;
(
    // clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_nrst,
    // avalon-mm slave
    input  wire logic [`EPIU_ADDR_W-1:0] i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    input  wire logic [3:0]              i_avs_byteenable,
    output logic      [31:0]             o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // register side of the bundle
    epiu_if.bus                          bus
);
    epiu_bus_type q;
    epiu_bus_type d;

    // capture read data on the first cycle, answer on the second
    always_comb begin
        d = q;
        case (q.st)
            EPIU_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    d.st = EPIU_ACK;
                    d.rdata = 32'(bus.rdata);
                end
            end
            EPIU_ACK: d.st = EPIU_IDLE;
            default:  d.st = EPIU_IDLE;
        endcase
    end

    assign o_avs_waitrequest = (i_avs_read || i_avs_write)
                             && (q.st == EPIU_IDLE);
    assign o_avs_readdata = q.rdata;
    assign bus.addr = i_avs_address;
    assign bus.wdata = i_avs_writedata[7:0];
    assign bus.wr = i_avs_write && (q.st == EPIU_ACK)
                  && i_avs_byteenable[0];

    // state register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= `EPIU_RST_REGS;
        end else begin
            q <= d;
        end
    end
endmodule

//--- rtl/epiu_top.sv
// epiu_top.sv: external pin interrupt unit, registers and requests
// assumes: cpu supplies the global enable bit and routine-entry pulses
// assumes: a power manager lowers i_io_clk_en in deep sleep
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`include "epiu_map.svh"

// ==========================================================
// Summary of operation
// RL1: pins trigger even when driven as outputs
// RL2: groups two, one, zero cover 23:16, 14:8, 7:0
// RL3: mask bits select contributing pin-change inputs
// RL4: pin-change wake works without io clock
// RL5: enabled low level requests while pin low
// RL6: edges need io clock, low level does not
// RL7: io clock stops outside idle sleep
// RL8: level wake interrupts only if still low
// RL9: request needs global and own enable
// RL10: pins sampled, pulses over one clock caught
// RL11: source holds low level until instruction ends
// RL12: sense codes low, any, falling, rising
// RL13: sense bits 3:2 pin one, 1:0 pin zero
// RL14: unused upper register bits read zero
// RL15: enable bit per pin, own vector each
// RL16: edge or change sets that pin's flag
// RL17: set flag branches when both enables set
// RL18: routine entry or write one clears flag
// RL19: flag held clear in low level mode
// RL20: group enable with global bit allows requests
// RL21: group flag set, cleared by entry or one
// RL22: dedicated pins synchronised, samples compared
module epiu_top
    import epiu_pkg::*;
#(
    parameter int PC_W = `EPIU_PC_W
)(
    // clock and reset
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_nrst,
    // avalon-mm slave
    input  wire logic [`EPIU_ADDR_W-1:0] i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    input  wire logic [3:0]              i_avs_byteenable,
    output logic      [31:0]             o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // interrupt pins
    input  wire logic                    i_ext_irq_pin_zero,
    input  wire logic                    i_ext_irq_pin_one,
    input  wire logic [PC_W-1:0]         i_pin_change_inputs,
    // cpu and power manager
    input  wire logic                    i_cpu_status_register_ie,
    input  wire logic                    i_io_clk_en,
    input  wire logic [4:0]              i_irq_ack,
    // requests to the cpu
    output logic      [4:0]              o_irq_req,
    output logic                         o_wake_req
);
    // ==========================================================
    // elaboration check

    if (PC_W != `EPIU_PC_W) begin : g_bad_width
        $error("epiu_top: pin-change width must be 24");
    end

    // ==========================================================
    // declarations

    epiu_if          u_if ();
    epiu_regs_type   r_q;
    epiu_regs_type   r_d;
    logic [1:0]      ext_low;
    logic [1:0]      ext_pins;
    logic [1:0]      ext_set;
    logic [1:0]      ext_clr;
    logic [1:0]      ext_req;
    logic [2:0]      pc_clr;
    logic [2:0]      pc_req;
    logic [2:0]      pc_wake;
    logic [23:0]     pc_diff;
    logic            wr_flag;
    logic            wr_pcflag;
    logic [2:0]      ext_flag_nx;

    // sticky flag update: set wins over any clear
    function automatic logic [2:0] flag_next(input logic [2:0] q,
                                             input logic [2:0] clr,
                                             input logic [2:0] set);
        flag_next = (q & ~clr) | set;
    endfunction

    // low level mode of a sense field
    function automatic logic is_low(input logic [1:0] s);
        is_low = (epiu_sense_type'(s) == EPIU_LOW); // RL12
    endfunction

    // ==========================================================
    // submodules

    // avalon-mm slave
    epiu_avmm u_avmm (
        .i_ref_clk         (i_ref_clk),
        .i_nrst            (i_nrst),
        .i_avs_address     (i_avs_address),
        .i_avs_read        (i_avs_read),
        .i_avs_write       (i_avs_write),
        .i_avs_writedata   (i_avs_writedata),
        .i_avs_byteenable  (i_avs_byteenable),
        .o_avs_readdata    (o_avs_readdata),
        .o_avs_waitrequest (o_avs_waitrequest),
        .bus               (u_if.bus)
    );

    // pin sampling and detection
    epiu_sync_det u_det (
        .i_ref_clk  (i_ref_clk),
        .i_nrst     (i_nrst),
        .i_ext_pins (ext_pins),
        .i_pc_pins  (i_pin_change_inputs),
        .i_io_en    (i_io_clk_en),
        .det        (u_if.det)
    );

    // ==========================================================
    // event decode

    // pins read whatever their direction
    assign ext_pins = {i_ext_irq_pin_one, i_ext_irq_pin_zero}; // RL1

    // configuration to the detectors
    assign u_if.sense = r_q.sense;
    assign u_if.pcmsk = r_q.pcmsk;

    // per-pin level mode
    assign ext_low[0] = is_low(r_q.sense[`EPIU_S0]); // RL13
    assign ext_low[1] = is_low(r_q.sense[`EPIU_S1]); // RL13

    // flag write strobes
    assign wr_flag = u_if.wr && (u_if.addr == `EPIU_OFS_FLAG);
    assign wr_pcflag = u_if.wr && (u_if.addr == `EPIU_OFS_PCFLAG);

    // edge events set flags only outside level mode
    assign ext_set = u_if.ext_evt & ~ext_low; // RL16

    // clear by routine entry or writing one
    assign ext_clr = i_irq_ack[1:0]
                   | (wr_flag ? u_if.wdata[1:0] : 2'h0); // RL18
    assign pc_clr = i_irq_ack[4:2]
                  | (wr_pcflag ? u_if.wdata[2:0] : 3'h0); // RL21

    // dedicated flags widened to share the sticky update
    assign ext_flag_nx = flag_next({1'b0, r_q.flag}, {1'b0, ext_clr},
                                   {1'b0, ext_set}); // RL16 RL18

    // ==========================================================
    // register next state

    always_comb begin
        r_d = r_q;
        // software writes to control registers
        if (u_if.wr) begin
            case (u_if.addr)
                `EPIU_OFS_SENSE: begin
                    r_d.sense = u_if.wdata[3:0]; // RL12 RL13
                end
                `EPIU_OFS_EN: begin
                    r_d.en = u_if.wdata[1:0]; // RL15
                end
                `EPIU_OFS_PCEN: begin
                    r_d.pcen = u_if.wdata[2:0]; // RL20
                end
                `EPIU_OFS_PIN_CHANGE_MASK_ZERO: begin
                    r_d.pcmsk[`EPIU_G0] = u_if.wdata; // RL3
                end
                `EPIU_OFS_PIN_CHANGE_MASK_ONE: begin
                    r_d.pcmsk[`EPIU_G1] =
                        {1'b0, u_if.wdata[`EPIU_G1_LIVE]}; // RL2 RL3
                end
                `EPIU_OFS_PIN_CHANGE_MASK_TWO: begin
                    r_d.pcmsk[`EPIU_G2] = u_if.wdata; // RL3
                end
                default: begin
                end
            endcase
        end
        // dedicated pin flags
        r_d.flag = ext_flag_nx[1:0]; // RL16 RL18
        // level mode keeps the flag clear
        if (is_low(r_d.sense[`EPIU_S0])) begin
            r_d.flag[0] = 1'b0; // RL19
        end
        if (is_low(r_d.sense[`EPIU_S1])) begin
            r_d.flag[1] = 1'b0; // RL19
        end
        // pin-change group flags
        r_d.pcflag = flag_next(r_q.pcflag, pc_clr, u_if.pc_evt); // RL21
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_q <= `EPIU_RST_REGS;
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // register read mux, reserved bits zero

    always_comb begin
        case (u_if.addr)
            `EPIU_OFS_SENSE:  u_if.rdata = {4'h0, r_q.sense}; // RL14
            `EPIU_OFS_EN:     u_if.rdata = {6'h00, r_q.en}; // RL14
            `EPIU_OFS_FLAG:   u_if.rdata = {6'h00, r_q.flag}; // RL14
            `EPIU_OFS_PCEN:   u_if.rdata = {5'h00, r_q.pcen};
            `EPIU_OFS_PCFLAG: u_if.rdata = {5'h00, r_q.pcflag};
            `EPIU_OFS_PIN_CHANGE_MASK_ZERO: u_if.rdata = r_q.pcmsk[`EPIU_G0];
            `EPIU_OFS_PIN_CHANGE_MASK_ONE: u_if.rdata = r_q.pcmsk[`EPIU_G1];
            `EPIU_OFS_PIN_CHANGE_MASK_TWO: u_if.rdata = r_q.pcmsk[`EPIU_G2];
            `EPIU_OFS_PINS:   u_if.rdata = {6'h00, u_if.ext_lvl};
            default:          u_if.rdata = 8'h00;
        endcase
    end

    // ==========================================================
    // requests to the cpu

    // level mode follows the pin, edge modes the flag
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ext_req[i] = i_cpu_status_register_ie && r_q.en[i]
                && (ext_low[i] ? !u_if.ext_lvl[i]
                               : r_q.flag[i]); // RL5 RL8 RL9 RL17
        end
    end

    // group requests
    assign pc_req = {3{i_cpu_status_register_ie}}
                  & r_q.pcen & r_q.pcflag; // RL20

    // one line per vector
    assign o_irq_req = {pc_req, ext_req}; // RL15

    // ==========================================================
    // clockless wake path

    // raw pin against the last sample held while clocks stop
    assign pc_diff = (i_pin_change_inputs ^ u_if.pc_prev) & r_q.pcmsk;
    assign pc_wake[0] = r_q.pcen[0] && |pc_diff[`EPIU_G0]; // RL4
    assign pc_wake[1] = r_q.pcen[1] && |pc_diff[`EPIU_G1]; // RL4
    assign pc_wake[2] = r_q.pcen[2] && |pc_diff[`EPIU_G2]; // RL4

    // low level on an enabled pin wakes with no clock
    assign o_wake_req = |(r_q.en & ext_low & ~ext_pins)
                      || |pc_wake; // RL6 RL11

    // ==========================================================
    // checks

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    // flag never set while pin zero is level sensed
    AST_LOW_FLAG_CLEAR: // RL19
    assert property (is_low(r_q.sense[`EPIU_S0]) |-> !r_q.flag[0])
        else $error("flag zero set in low level mode");

    // detected edge lands in the flag next cycle
    AST_EDGE_SETS_FLAG: // RL16
    assert property (u_if.ext_evt[1]
        && !(u_if.wr && u_if.addr == `EPIU_OFS_SENSE)
        |=> r_q.flag[1])
        else $error("edge on pin one did not set its flag");

    // routine entry clears the flag
    AST_ACK_CLEARS: // RL18
    assert property (i_irq_ack[0] && !u_if.ext_evt[0] |=> !r_q.flag[0])
        else $error("flag zero survived routine entry");

    // writing zero leaves the flag alone
    AST_W1C_ZERO_KEEPS: // RL18
    assert property (wr_flag && !u_if.wdata[0] && !i_irq_ack[0]
        && r_q.flag[0] |=> r_q.flag[0])
        else $error("writing zero cleared flag zero");

    // no request without both enables
    AST_REQ_GATED: // RL9
    assert property (o_irq_req[1] |-> i_cpu_status_register_ie
        && r_q.en[1])
        else $error("pin one request without enables");

    // low pin in level mode keeps requesting
    AST_LEVEL_HOLDS: // RL5
    assert property (r_q.en[0] && i_cpu_status_register_ie
        && ext_low[0] && !u_if.ext_lvl[0] |-> o_irq_req[0])
        else $error("level request missing on pin zero");

    // fully masked group never raises its flag
    AST_MASKED_SILENT: // RL3
    assert property (r_q.pcmsk[`EPIU_G0] == 8'h00 && !r_q.pcflag[0]
        |=> !r_q.pcflag[0])
        else $error("masked group zero raised its flag");

    // enabled toggle on input sixteen sets group two
    AST_GROUP_TWO: // RL2
    assert property ($changed(u_if.pc_prev[16])
        && $past(r_q.pcmsk[16]) |-> r_q.pcflag[2])
        else $error("toggle on input sixteen missed group two");

    // flag read returns the flag, upper bits zero
    AST_FLAG_READ: // RL14
    assert property (i_avs_read && !o_avs_waitrequest
        && i_avs_address == `EPIU_OFS_FLAG
        |-> o_avs_readdata == 32'($past(r_q.flag)))
        else $error("flag register read mismatch");

    // pin one flag stays clear in level mode
    AST_LOW_FLAG_ONE: // RL19
    assert property (is_low(r_q.sense[`EPIU_S1]) |-> !r_q.flag[1])
        else $error("flag one set in low level mode");

    // group zero request needs both enables
    AST_GROUP_GATED: // RL20
    assert property (o_irq_req[2] |-> i_cpu_status_register_ie
        && r_q.pcen[0])
        else $error("group zero request without enables");

    // routine entry clears group two flag
    AST_GROUP_ACK: // RL21
    assert property (i_irq_ack[4] && !u_if.pc_evt[2] |=> !r_q.pcflag[2])
        else $error("group two flag survived routine entry");

    // no detector event while the io clock is off
    AST_IO_OFF_QUIET: // RL7
    assert property (!i_io_clk_en |-> u_if.ext_evt == 2'h0
        && u_if.pc_evt == 3'h0)
        else $error("event detected with io clock off");

    // low level on enabled pin zero wakes the part
    AST_WAKE_LEVEL: // RL6
    assert property (r_q.en[0] && ext_low[0] && !i_ext_irq_pin_zero
        |-> o_wake_req)
        else $error("no wake on low level of pin zero");

    // read data upper bits always zero
    AST_READ_UPPER_ZERO: // RL14
    assert property (i_avs_read && !o_avs_waitrequest
        |-> o_avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

endmodule

//--- testbench/epiu_pin_src.sv
// epiu_pin_src.sv: model of the sources on the interrupt pins
// assumes: pins idle high behind pull-ups; bench calls its tasks
module epiu_pin_src
(
    // clock
    input  wire logic        i_ref_clk,
    // pins towards the unit
    output logic             o_pin_zero,
    output logic             o_pin_one,
    output logic [23:0]      o_pc_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // all sources idle high at start
    initial begin
        o_pin_zero = 1'h1;
        o_pin_one  = 1'h1;
        o_pc_pins  = 24'hff_ffff;
    end
    // drive a dedicated pin, then hold it two edges at least
    task automatic set_ext(input int p, input logic v);
        @(posedge i_ref_clk);
        if (p == 0) o_pin_zero <= v;
        else o_pin_one <= v;
        repeat (2) @(posedge i_ref_clk);
    endtask
    // flip one pin-change input and hold it
    task automatic flip_pc(input int n);
        @(posedge i_ref_clk);
        o_pc_pins[n] <= ~o_pc_pins[n];
        repeat (2) @(posedge i_ref_clk);
    endtask
endmodule

//--- testbench/tb.sv
// tb.sv: self-checking bench of the external pin interrupt unit
// assumes: rtl files and epiu_pin_src compiled before it
`include "epiu_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // =====
    // stimulus and observed signals
    logic                    ref_clk = 1'h0;
    logic                    nrst    = 1'h0;
    logic [`EPIU_ADDR_W-1:0] address = '0;
    logic                    rd      = 1'h0;
    logic                    wr      = 1'h0;
    logic [31:0]             wdata   = '0;
    logic [31:0]             rdata;
    logic [3:0]              be      = 4'h1;
    logic                    waitreq;
    logic                    ie      = 1'h0;
    logic                    io_en   = 1'h1;
    logic                    wake;
    logic [4:0]              ack     = 5'h0;
    logic [4:0]              req;
    logic                    pin0;
    logic                    pin1;
    logic [23:0]             pcp;
    int                      bad_count   = 0;
    int                      checks_done = 0;
    logic [7:0]              fw [8] = '{8'h0f, 8'h03, 8'h00, 8'h07,
                                        8'h00, 8'hff, 8'h7f, 8'hff};
    // clock at 100 MHz
    always #5 ref_clk = ~ref_clk;
    // =====
    // unit and pin sources
    epiu_top DUT (
        .i_ref_clk(ref_clk), .i_nrst(nrst),
        .i_avs_address(address), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .i_ext_irq_pin_zero(pin0), .i_ext_irq_pin_one(pin1),
        .i_pin_change_inputs(pcp), .i_cpu_status_register_ie(ie),
        .i_io_clk_en(io_en), .i_irq_ack(ack),
        .o_irq_req(req), .o_wake_req(wake)
    );
    epiu_pin_src SRC (
        .i_ref_clk(ref_clk), .o_pin_zero(pin0),
        .o_pin_one(pin1), .o_pc_pins(pcp)
    );
    // =====
    // verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // compare one value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    // one avalon transfer, held until waitrequest is low
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        address <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitreq !== 1'h0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            stop_test();
        end
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic wr8(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        check(q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // =====
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        stop_test();
    end
    // main sequence
    initial begin
        int idx;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'h1;
        // reset values, writable bits, ignored writes
        for (int i = 0; i < 8; i++) begin
            rd_chk(6'(4 * i), 32'h0);
            wr8(6'(4 * i), 32'hff);
            rd_chk(6'(4 * i), {24'h0, fw[i]});
            wr8(6'(4 * i), 32'h0);
        end
        be <= 4'h0;
        wr8(`EPIU_OFS_SENSE, 32'h5);
        be <= 4'h1;
        rd_chk(`EPIU_OFS_SENSE, 32'h0);
        wr8(6'h24, 32'hff);
        rd_chk(6'h24, 32'h0);
        rd_chk(`EPIU_OFS_PINS, 32'h3);
        // every sense code on both dedicated pins
        ie <= 1'h1;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr8(`EPIU_OFS_SENSE, 32'(c << (2 * p)));
                wr8(`EPIU_OFS_EN, 32'(1 << p));
                wr8(`EPIU_OFS_FLAG, 32'h3);
                SRC.set_ext(p, 1'h0);
                cyc(4);
                check(req[p], c != 3);
                rd_chk(`EPIU_OFS_FLAG, 32'(c == 1 || c == 2) << p);
                SRC.set_ext(p, 1'h1);
                cyc(4);
                wr8(`EPIU_OFS_FLAG, 32'h0);
                rd_chk(`EPIU_OFS_FLAG, 32'(c != 0) << p);
                check(req[p], c != 0);
                ie <= 1'h0;
                cyc(1);
                check(req[p], 1'h0);
                ie <= 1'h1;
                if (c[0]) begin
                    ack <= 5'(1 << p);
                    cyc(1);
                    ack <= 5'h0;
                end
                else wr8(`EPIU_OFS_FLAG, 32'(1 << p));
                rd_chk(`EPIU_OFS_FLAG, 32'h0);
            end
        end
        // edges missed while the io clock is off
        wr8(`EPIU_OFS_SENSE, 32'h2);
        wr8(`EPIU_OFS_EN, 32'h1);
        io_en <= 1'h0;
        SRC.set_ext(0, 1'h0);
        SRC.set_ext(0, 1'h1);
        io_en <= 1'h1;
        cyc(6);
        rd_chk(`EPIU_OFS_FLAG, 32'h0);
        // low level wakes with no clock
        wr8(`EPIU_OFS_SENSE, 32'h0);
        io_en <= 1'h0;
        SRC.set_ext(0, 1'h0);
        check(wake, 1'h1);
        SRC.set_ext(0, 1'h1);
        check(wake, 1'h0);
        io_en <= 1'h1;
        // pin-change groups, masked then unmasked
        wr8(`EPIU_OFS_EN, 32'h0);
        wr8(`EPIU_OFS_PCEN, 32'h7);
        for (int g = 0; g < 3; g++) begin
            idx = 8 * g + 1;
            SRC.flip_pc(idx);
            cyc(4);
            rd_chk(`EPIU_OFS_PCFLAG, 32'h0);
            wr8(6'(`EPIU_OFS_PIN_CHANGE_MASK_ZERO + 4 * g), 32'h2);
            SRC.flip_pc(idx);
            cyc(4);
            rd_chk(`EPIU_OFS_PCFLAG, 32'(1 << g));
            check(req[2 + g], 1'h1);
            if (g == 2) begin
                ack <= 5'(4 << g);
                cyc(1);
                ack <= 5'h0;
            end
            else wr8(`EPIU_OFS_PCFLAG, 32'(1 << g));
            rd_chk(`EPIU_OFS_PCFLAG, 32'h0);
            wr8(6'(`EPIU_OFS_PIN_CHANGE_MASK_ZERO + 4 * g), 32'h0);
        end
        // pin change wakes with no clock
        wr8(`EPIU_OFS_PIN_CHANGE_MASK_ZERO, 32'h2);
        io_en <= 1'h0;
        SRC.flip_pc(1);
        check(wake, 1'h1);
        SRC.flip_pc(1);
        io_en <= 1'h1;
        cyc(6);
        stop_test();
    end
endmodule
